// ===== verilog/bbx_cfg.svh
// constants of the bit-band bridge and exclusive monitor
`ifndef BBX_CFG_SVH
`define BBX_CFG_SVH
`define BBX_SRAM_ALIAS_BASE 32'h2200_0000
`define BBX_PERI_ALIAS_BASE 32'h4200_0000
`define BBX_SRAM_BB_BASE 32'h2000_0000
`define BBX_PERI_BB_BASE 32'h4000_0000
`define BBX_ALIAS_LSB 25
`define BBX_BYTE_MSB 24
`define BBX_BYTE_LSB 5
`define BBX_BIT_MSB 4
`define BBX_BIT_LSB 2
`define BBX_BB_ZERO 12'h000
`define BBX_STATUS_OK 1'b0
`define BBX_STATUS_FAIL 1'b1
`define BBX_BE_BYTE 4'h1
`define BBX_BE_HALF 4'h3
`define BBX_BE_WORD 4'hf
`define BBX_MASK_BYTE 32'h0000_00ff
`define BBX_MASK_HALF 32'h0000_ffff
`define BBX_MASK_WORD 32'hffff_ffff
`endif

// ===== verilog/bbx_pkg.sv
// types of the bit-band bridge and exclusive monitor
package bbx_pkg;
  typedef enum logic [1:0] {
    BBX_SIZE_BYTE = 2'h0,
    BBX_SIZE_HALF = 2'h1,
    BBX_SIZE_WORD = 2'h2
  } bbx_size_t;
  typedef enum logic [1:0] {
    BBX_OP_PLAIN = 2'h0,
    BBX_OP_LOAD_EXCL = 2'h1,
    BBX_OP_STORE_EXCL = 2'h2
  } bbx_op_t;
  typedef enum logic [4:0] {
    BBX_ST_IDLE = 5'h01,
    BBX_ST_RD_REQ = 5'h02,
    BBX_ST_RD_WAIT = 5'h04,
    BBX_ST_WR_REQ = 5'h08,
    BBX_ST_DONE = 5'h10
  } bbx_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    bbx_size_t size;
    bbx_op_t op;
  } bbx_core_req_t;
  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } bbx_mem_req_t;
endpackage

// ===== verilog/bbx_alias_decode.sv
// alias address decoder onto bit-band byte and bit number
`timescale 1ns/1ps
`include "bbx_cfg.svh"
module bbx_alias_decode (
  input wire logic [31:0] addr,
  output logic is_alias,
  output logic [31:0] bb_addr,
  output logic [2:0] bit_num
);
  logic hit_sram;
  logic hit_peri;
  logic [31:0] bb_base;
  always_comb begin
    hit_sram = addr[31:`BBX_ALIAS_LSB] == 7'(`BBX_SRAM_ALIAS_BASE >> `BBX_ALIAS_LSB); // RQ3
    hit_peri = addr[31:`BBX_ALIAS_LSB] == 7'(`BBX_PERI_ALIAS_BASE >> `BBX_ALIAS_LSB); // RQ4
    is_alias = hit_sram | hit_peri;
    bb_base = hit_peri ? `BBX_PERI_BB_BASE : `BBX_SRAM_BB_BASE;
    // offset = byte * 32 + bit * 4
    bb_addr = bb_base | {`BBX_BB_ZERO, addr[`BBX_BYTE_MSB:`BBX_BYTE_LSB]}; // RQ1
    bit_num = addr[`BBX_BIT_MSB:`BBX_BIT_LSB]; // RQ2
  end
endmodule

// ===== verilog/bbx_bridge.sv
// bit-band bridge with local exclusive-access monitor
//
// Behaviour
// RQ1 - alias = base + byte*32 + bit*4
// RQ2 - bit number covers byte bits 0 to 7
// RQ3 - sram alias 0x22000000 maps byte 0x20000000
// RQ4 - peripheral alias maps peripheral bit-band likewise
// RQ5 - alias write is read-modify-write of one bit
// RQ6 - written bit 0 becomes the target bit
// RQ7 - upper 31 written bits are ignored
// RQ8 - alias read returns 0 or 1
// RQ9 - words stored little-endian
// RQ10 - exclusive load/store in word, half, byte
// RQ11 - exclusive load sets the local tag
// RQ12 - exclusive store status 0 writes, 1 skips
// RQ13 - clear-exclusive drops the local tag
// RQ14 - every exclusive store drops the local tag
// RQ15 - exception drops the local tag
// RQ16 - global tags kept for exclusive addresses
// RQ17 - clear-exclusive leaves global tags alone
// RQ18 - store or exception clears global tags too
// RQ19 - requester pairs load and store sizes
// RQ20 - requester retries whole sequence on failure
// RQ21 - untagged exclusive store fails, memory unchanged
`timescale 1ns/1ps
`include "bbx_cfg.svh"
module bbx_bridge (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic core_req_valid,
  output logic core_req_ready,
  input wire bbx_pkg::bbx_core_req_t core_req,
  output logic core_rsp_valid,
  output logic [31:0] core_rsp_data,
  output logic core_rsp_status,
  input wire logic clear_exclusive_tag,
  input wire logic exception_taken,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output bbx_pkg::bbx_mem_req_t mem_req,
  input wire logic mem_rsp_valid,
  input wire logic [31:0] mem_rsp_data,
  output logic excl_tag,
  output logic global_tag_set,
  output logic [31:0] global_tag_addr,
  output logic global_tag_clear
);
  // ****************************************
  // decode and state
  // ****************************************
  bbx_pkg::bbx_state_t state;
  bbx_pkg::bbx_state_t next_state;
  logic dec_alias;
  logic [31:0] dec_bb;
  logic [2:0] dec_bit;
  logic acc;
  logic r_alias;
  logic r_write;
  bbx_pkg::bbx_op_t r_op;
  bbx_pkg::bbx_size_t r_size;
  logic [31:0] r_wdata;
  logic [1:0] r_lane;
  logic [4:0] r_bitidx;
  logic next_alias;
  logic next_write;
  bbx_pkg::bbx_op_t next_op;
  bbx_pkg::bbx_size_t next_size;
  logic [31:0] next_wdata;
  logic [1:0] next_lane;
  logic [4:0] next_bitidx;
  bbx_pkg::bbx_mem_req_t next_mem_req;
  logic [31:0] next_rsp_data;
  logic next_rsp_status;
  logic next_tag;
  logic next_gset;
  logic [31:0] next_gaddr;
  logic next_gclr;
  logic [31:0] lane_addr;
  logic [4:0] shift;
  logic [3:0] be;
  logic [31:0] mask;
  logic [31:0] rmw_word;
  bbx_alias_decode u_decode (
    .addr(core_req.addr),
    .is_alias(dec_alias),
    .bb_addr(dec_bb),
    .bit_num(dec_bit)
  );
  assign core_req_ready = state == bbx_pkg::BBX_ST_IDLE;
  assign core_rsp_valid = state == bbx_pkg::BBX_ST_DONE;
  assign mem_req_valid = (state == bbx_pkg::BBX_ST_RD_REQ) || (state == bbx_pkg::BBX_ST_WR_REQ);
  assign acc = core_req_valid && core_req_ready;
  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    next_state = state;
    next_alias = r_alias;
    next_write = r_write;
    next_op = r_op;
    next_size = r_size;
    next_wdata = r_wdata;
    next_lane = r_lane;
    next_bitidx = r_bitidx;
    next_mem_req = mem_req;
    next_rsp_data = core_rsp_data;
    next_rsp_status = core_rsp_status;
    next_gset = 1'b0;
    next_gaddr = global_tag_addr;
    next_gclr = 1'b0;
    lane_addr = dec_alias ? dec_bb : core_req.addr;
    shift = {lane_addr[1:0], 3'b000};
    case (core_req.size) // RQ10
      bbx_pkg::BBX_SIZE_BYTE: be = `BBX_BE_BYTE;
      bbx_pkg::BBX_SIZE_HALF: be = `BBX_BE_HALF;
      default: be = `BBX_BE_WORD;
    endcase
    case (r_size)
      bbx_pkg::BBX_SIZE_BYTE: mask = `BBX_MASK_BYTE;
      bbx_pkg::BBX_SIZE_HALF: mask = `BBX_MASK_HALF;
      default: mask = `BBX_MASK_WORD;
    endcase
    rmw_word = mem_rsp_data;
    rmw_word[r_bitidx] = r_wdata[0]; // RQ6 RQ7
    // local tag: a load-exclusive set wins over any clear in the same cycle
    next_tag = excl_tag;
    if (clear_exclusive_tag || exception_taken) begin
      next_tag = 1'b0; // RQ13 RQ15 RQ17
    end
    if (acc && core_req.op == bbx_pkg::BBX_OP_STORE_EXCL) begin
      next_tag = 1'b0; // RQ14
    end
    if (acc && core_req.op == bbx_pkg::BBX_OP_LOAD_EXCL) begin
      next_tag = 1'b1; // RQ11
    end
    if (exception_taken) begin
      next_gclr = 1'b1; // RQ18
    end
    case (state)
      bbx_pkg::BBX_ST_IDLE: begin
        if (acc) begin
          next_alias = dec_alias;
          next_write = core_req.write;
          next_op = core_req.op;
          next_size = core_req.size;
          next_wdata = core_req.wdata;
          next_lane = lane_addr[1:0];
          next_bitidx = {lane_addr[1:0], dec_bit}; // RQ2
          next_mem_req.addr = {lane_addr[31:2], 2'b00};
          next_mem_req.write = 1'b0;
          // little-endian lane placement
          next_mem_req.wdata = core_req.wdata << shift; // RQ9
          next_mem_req.be = be << lane_addr[1:0]; // RQ9
          next_rsp_status = `BBX_STATUS_OK;
          if (core_req.op == bbx_pkg::BBX_OP_LOAD_EXCL) begin
            next_gset = 1'b1; // RQ16
            next_gaddr = core_req.addr;
          end
          if (core_req.op == bbx_pkg::BBX_OP_STORE_EXCL) begin
            next_gclr = 1'b1; // RQ18
          end
          if (core_req.op == bbx_pkg::BBX_OP_STORE_EXCL && !excl_tag) begin
            next_rsp_status = `BBX_STATUS_FAIL; // RQ12 RQ21
            next_rsp_data = 32'h0000_0000;
            next_state = bbx_pkg::BBX_ST_DONE;
          end else if (core_req.write && !dec_alias) begin
            next_mem_req.write = 1'b1;
            next_state = bbx_pkg::BBX_ST_WR_REQ; // RQ12
          end else begin
            next_state = bbx_pkg::BBX_ST_RD_REQ; // RQ5
          end
        end
      end
      bbx_pkg::BBX_ST_RD_REQ: begin
        if (mem_req_ready) begin
          next_state = bbx_pkg::BBX_ST_RD_WAIT;
        end
      end
      bbx_pkg::BBX_ST_RD_WAIT: begin
        if (mem_rsp_valid) begin
          if (r_alias && r_write) begin
            next_mem_req.write = 1'b1;
            next_mem_req.wdata = rmw_word; // RQ5
            next_mem_req.be = `BBX_BE_BYTE << r_lane; // RQ5
            next_state = bbx_pkg::BBX_ST_WR_REQ;
          end else if (r_alias) begin
            next_rsp_data = {31'h0000_0000, mem_rsp_data[r_bitidx]}; // RQ8
            next_state = bbx_pkg::BBX_ST_DONE;
          end else begin
            next_rsp_data = (mem_rsp_data >> {r_lane, 3'b000}) & mask; // RQ9
            next_state = bbx_pkg::BBX_ST_DONE;
          end
        end
      end
      bbx_pkg::BBX_ST_WR_REQ: begin
        if (mem_req_ready) begin
          next_rsp_data = 32'h0000_0000;
          next_state = bbx_pkg::BBX_ST_DONE;
        end
      end
      bbx_pkg::BBX_ST_DONE: begin
        next_state = bbx_pkg::BBX_ST_IDLE;
      end
      default: begin
        next_state = bbx_pkg::BBX_ST_IDLE;
      end
    endcase
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= bbx_pkg::BBX_ST_IDLE;
      r_alias <= 1'b0;
      r_write <= 1'b0;
      r_op <= bbx_pkg::BBX_OP_PLAIN;
      r_size <= bbx_pkg::BBX_SIZE_WORD;
      r_wdata <= 32'h0000_0000;
      r_lane <= 2'h0;
      r_bitidx <= 5'h00;
      mem_req <= '0;
      core_rsp_data <= 32'h0000_0000;
      core_rsp_status <= `BBX_STATUS_OK;
      excl_tag <= 1'b0;
      global_tag_set <= 1'b0;
      global_tag_addr <= 32'h0000_0000;
      global_tag_clear <= 1'b0;
    end else begin
      state <= next_state;
      r_alias <= next_alias;
      r_write <= next_write;
      r_op <= next_op;
      r_size <= next_size;
      r_wdata <= next_wdata;
      r_lane <= next_lane;
      r_bitidx <= next_bitidx;
      mem_req <= next_mem_req;
      core_rsp_data <= next_rsp_data;
      core_rsp_status <= next_rsp_status;
      excl_tag <= next_tag;
      global_tag_set <= next_gset;
      global_tag_addr <= next_gaddr;
      global_tag_clear <= next_gclr;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic acc_ld;
  logic acc_st;
  logic acc_alias_wr;
  assign acc_ld = acc && core_req.op == bbx_pkg::BBX_OP_LOAD_EXCL;
  assign acc_st = acc && core_req.op == bbx_pkg::BBX_OP_STORE_EXCL;
  assign acc_alias_wr = acc && dec_alias && core_req.write && !(acc_st && !excl_tag);
  sequence s_st_fail;
    acc_st && !excl_tag;
  endsequence
  sequence s_rd_phase;
    mem_req_valid && !mem_req.write;
  endsequence
  sequence s_fail_answer;
    core_rsp_valid && core_rsp_status == `BBX_STATUS_FAIL && !mem_req_valid;
  endsequence
  sequence s_rmw_read;
    state == bbx_pkg::BBX_ST_RD_WAIT && mem_rsp_valid && r_alias && r_write;
  endsequence
  alias_decode_map_a: assert property ( // RQ1
    dec_alias |-> {dec_bb[19:0], dec_bit, 2'b00} == core_req.addr[24:0] &&
      dec_bb[31:20] == (core_req.addr[30] ? 12'h400 : 12'h200))
    else $error("alias address decoded to wrong bit-band location");
  sram_alias_base_a: assert property ( // RQ3
    core_req.addr == `BBX_SRAM_ALIAS_BASE |-> dec_alias && dec_bb == `BBX_SRAM_BB_BASE &&
      dec_bit == 3'h0)
    else $error("first sram alias word not bit 0 of first bit-band byte");
  store_fail_a: assert property ( // RQ21
    s_st_fail |=> s_fail_answer)
    else $error("untagged exclusive store did not fail cleanly");
  tag_set_a: assert property ( // RQ11
    acc_ld |=> excl_tag)
    else $error("exclusive load did not set the tag");
  tag_clear_a: assert property ( // RQ13 RQ14 RQ15
    (clear_exclusive_tag || exception_taken || acc_st) && !acc_ld |=> !excl_tag)
    else $error("tag survived a clear event");
  global_keep_a: assert property ( // RQ17
    clear_exclusive_tag && !exception_taken && !acc_st |=> !global_tag_clear)
    else $error("clear-exclusive touched global tags");
  global_drop_a: assert property ( // RQ18
    exception_taken || acc_st |=> global_tag_clear)
    else $error("global tags not cleared");
  rmw_read_first_a: assert property ( // RQ5
    acc_alias_wr |=> s_rd_phase)
    else $error("alias write did not start with a read");
  rmw_sequence_a: assert property ( // RQ5 RQ6
    s_rmw_read |=> mem_req_valid && mem_req.write && mem_req.wdata[r_bitidx] == r_wdata[0] &&
      mem_req.be == (`BBX_BE_BYTE << r_lane))
    else $error("alias write not done as read-modify-write");
  alias_read_a: assert property ( // RQ8
    core_rsp_valid && r_alias && !r_write |-> core_rsp_data[31:1] == 31'h0000_0000)
    else $error("alias read returned more than one bit");
  store_ok_a: assert property ( // RQ12
    acc_st && excl_tag && !dec_alias |=> mem_req_valid && mem_req.write)
    else $error("tagged exclusive store did not write");
endmodule

// ===== verification/bbx_mem_model.sv
// memory partner model for the bit-band bridge
`timescale 1ns/1ps
module bbx_mem_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire bbx_pkg::bbx_mem_req_t mem_req,
  output logic mem_rsp_valid,
  output logic [31:0] mem_rsp_data
);
  // ****************************************
  // word store with byte lanes
  // ****************************************
  logic [31:0] mem [64];
  logic [5:0] idx;
  assign idx = {mem_req.addr[30], mem_req.addr[6:2]};
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 32'h0;
      end
      mem_req_ready <= 1'b1;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 32'h0;
    end else begin
      // slow mode accepts only every other cycle
      mem_req_ready <= slow ? ~mem_req_ready : 1'b1;
      mem_rsp_valid <= 1'b0;
      // released data line shows a changing pattern
      mem_rsp_data <= ~mem_rsp_data;
      if (mem_req_valid && mem_req_ready) begin
        if (mem_req.write) begin
          for (int b = 0; b < 4; b++) begin
            if (mem_req.be[b]) begin
              mem[idx][8*b+:8] <= mem_req.wdata[8*b+:8];
            end
          end
        end else begin
          mem_rsp_valid <= 1'b1;
          mem_rsp_data <= mem[idx];
        end
      end
    end
  end
endmodule

// ===== verification/bitband_exclusive_monitor_test.sv
// testbench of the bit-band bridge and exclusive monitor
`timescale 1ns/1ps
module bitband_exclusive_monitor_test;
  // ****************************************
  // signals and instances
  // ****************************************
  logic sys_clk, reset, slow, core_req_valid, core_req_ready, core_rsp_valid;
  logic core_rsp_status, clear_exclusive_tag, exception_taken, mem_req_valid;
  logic mem_req_ready, mem_rsp_valid, excl_tag, global_tag_set, global_tag_clear, saw_set;
  logic [31:0] core_rsp_data, mem_rsp_data, global_tag_addr, rdat;
  logic st;
  bbx_pkg::bbx_core_req_t core_req;
  bbx_pkg::bbx_mem_req_t mem_req;
  int errors, total_checks, cycles;
  bbx_bridge DUT (.sys_clk(sys_clk), .reset(reset), .core_req_valid(core_req_valid),
    .core_req_ready(core_req_ready), .core_req(core_req), .core_rsp_valid(core_rsp_valid),
    .core_rsp_data(core_rsp_data), .core_rsp_status(core_rsp_status),
    .clear_exclusive_tag(clear_exclusive_tag), .exception_taken(exception_taken),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .excl_tag(excl_tag),
    .global_tag_set(global_tag_set), .global_tag_addr(global_tag_addr),
    .global_tag_clear(global_tag_clear));
  bbx_mem_model mem_model (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic access(input logic [31:0] a, input logic [31:0] d, input logic w,
      input bbx_pkg::bbx_size_t s, input bbx_pkg::bbx_op_t o);
    int n;
    n = 0;
    @(negedge sys_clk);
    core_req = '{addr: a, wdata: d, write: w, size: s, op: o};
    core_req_valid = 1'b1;
    while (core_req_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    core_req_valid = 1'b0;
    saw_set = global_tag_set;
    while (core_rsp_valid !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) begin
      check(32'(n), 32'h0);
    end
    rdat = core_rsp_data;
    st = core_rsp_status;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input bbx_pkg::bbx_size_t s);
    access(a, d, 1'b1, s, bbx_pkg::BBX_OP_PLAIN);
    check(32'(st), 32'h0);
  endtask
  task automatic rd(input logic [31:0] a, input bbx_pkg::bbx_size_t s, input logic [31:0] e);
    access(a, 32'h0, 1'b0, s, bbx_pkg::BBX_OP_PLAIN);
    check(rdat, e);
  endtask
  task automatic excl(input logic [31:0] d, input bbx_pkg::bbx_size_t s, input logic e);
    access(32'h2000_0020, 32'h0, 1'b0, s, bbx_pkg::BBX_OP_LOAD_EXCL);
    check(32'({excl_tag, saw_set}), 32'h3);
    check(global_tag_addr, 32'h2000_0020);
    access(32'h2000_0020, d, 1'b1, s, bbx_pkg::BBX_OP_STORE_EXCL);
    check(32'({st, excl_tag}), 32'({e, 1'b0}));
  endtask
  task automatic pulse(input logic exc);
    access(32'h2000_0020, 32'h0, 1'b0, bbx_pkg::BBX_SIZE_WORD, bbx_pkg::BBX_OP_LOAD_EXCL);
    exception_taken = exc;
    clear_exclusive_tag = ~exc;
    @(negedge sys_clk);
    exception_taken = 1'b0;
    clear_exclusive_tag = 1'b0;
    check(32'({global_tag_clear, excl_tag}), 32'({exc, 1'b0}));
    access(32'h2000_0020, 32'h0, 1'b1, bbx_pkg::BBX_SIZE_WORD, bbx_pkg::BBX_OP_STORE_EXCL);
    check(32'(st), 32'h1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic little_endian();
    slow = 1'b1;
    wr(32'h2000_0010, 32'h4433_2211, bbx_pkg::BBX_SIZE_WORD);
    rd(32'h2000_0011, bbx_pkg::BBX_SIZE_BYTE, 32'h22);
    rd(32'h2000_0012, bbx_pkg::BBX_SIZE_HALF, 32'h4433);
    slow = 1'b0;
  endtask
  task automatic alias_bits();
    wr(32'h2200_022c, 32'hff, bbx_pkg::BBX_SIZE_WORD);
    rd(32'h2200_022c, bbx_pkg::BBX_SIZE_WORD, 32'h1);
    rd(32'h2000_0010, bbx_pkg::BBX_SIZE_WORD, 32'h4433_2a11);
    wr(32'h2200_022c, 32'h0e, bbx_pkg::BBX_SIZE_WORD);
    rd(32'h2000_0010, bbx_pkg::BBX_SIZE_WORD, 32'h4433_2211);
    rd(32'h2200_0220, bbx_pkg::BBX_SIZE_WORD, 32'h0);
    rd(32'h2200_0224, bbx_pkg::BBX_SIZE_WORD, 32'h1);
    wr(32'h4200_001c, 32'h1, bbx_pkg::BBX_SIZE_WORD);
    rd(32'h4000_0000, bbx_pkg::BBX_SIZE_WORD, 32'h80);
  endtask
  task automatic exclusive();
    access(32'h2000_0020, 32'h5a, 1'b1, bbx_pkg::BBX_SIZE_WORD, bbx_pkg::BBX_OP_STORE_EXCL);
    check(32'(st), 32'h1);
    rd(32'h2000_0020, bbx_pkg::BBX_SIZE_WORD, 32'h0);
    excl(32'ha5, bbx_pkg::BBX_SIZE_BYTE, 1'b0);
    rd(32'h2000_0020, bbx_pkg::BBX_SIZE_WORD, 32'ha5);
    excl(32'hbeef, bbx_pkg::BBX_SIZE_HALF, 1'b0);
    rd(32'h2000_0020, bbx_pkg::BBX_SIZE_WORD, 32'hbeef);
    excl(32'h1234_5678, bbx_pkg::BBX_SIZE_WORD, 1'b0);
    access(32'h2000_0020, 32'h9, 1'b1, bbx_pkg::BBX_SIZE_WORD, bbx_pkg::BBX_OP_STORE_EXCL);
    check(32'(st), 32'h1);
    pulse(1'b0);
    excl(32'h77, bbx_pkg::BBX_SIZE_WORD, 1'b0);
    pulse(1'b1);
    rd(32'h2000_0020, bbx_pkg::BBX_SIZE_WORD, 32'h77);
  endtask
  // ****************************************
  // clock, reset, timeout and sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    {reset, slow, core_req_valid, clear_exclusive_tag, exception_taken} = 5'h10;
    core_req = '0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    little_endian();
    alias_bits();
    exclusive();
    finish_test();
  end
endmodule
